// ### rtl/pwrsq_seq.sv
// Wake and awake power sequencer with its AHB-Lite register slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pwrsq_seq #(
  parameter int DWELL_CNT_W = 32
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Sequencer events
  input  wire logic                  wake_req,
  input  wire logic                  seq_tick,
  input  wire pwrsq_pkg::pwrsq_good_s supply_good,
  // Supply and tile clock controls, and state code
  output pwrsq_pkg::pwrsq_cfg_s      supply_ctrl,
  output logic      [2:0]            seq_state
);

  // Longest dwell is 2^31 ticks; a narrower counter would end that dwell at once
  if (DWELL_CNT_W < (1 << pwrsq_pkg::DWELL_W)) begin : g_bad_dwell_w
    $error("DWELL_CNT_W must hold 2^31");
  end

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  logic [7:0]  addr_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [31:0] rdata_q;
  logic        ready_q;
  logic [31:0] wake1_q;
  logic [31:0] wake2_q;
  logic [31:0] awake_q;
  logic        sleep_req_q;
  logic        reapply_q;

  wire         take    = hsel & htrans[1] & hready;
  wire         wr_ctrl = wr_pend_q & (addr_q == pwrsq_pkg::ADDR_CTRL);
  wire         wr_w1   = wr_pend_q & (addr_q == pwrsq_pkg::ADDR_WAKE1);
  wire         wr_w2   = wr_pend_q & (addr_q == pwrsq_pkg::ADDR_WAKE2);
  wire         wr_aw   = wr_pend_q & (addr_q == pwrsq_pkg::ADDR_AWAKE);

  pwrsq_pkg::pwrsq_state_e state_q;
  pwrsq_pkg::pwrsq_state_e state_d;

  // Reserved and unmapped locations read zero
  wire  [31:0] rd_sel =
      (addr_q == pwrsq_pkg::ADDR_WAKE1)  ? wake1_q :
      (addr_q == pwrsq_pkg::ADDR_WAKE2)  ? wake2_q :
      (addr_q == pwrsq_pkg::ADDR_AWAKE)  ? awake_q :
      (addr_q == pwrsq_pkg::ADDR_STATUS) ?
        (32'(pwrsq_pkg::state_code(state_q)) << pwrsq_pkg::STATUS_LSB) :
      32'h0000_0000;

  assign hresp = 1'b0;

  // Reads get one wait state so that a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q   <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else begin
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      ready_q   <= ~(take & ~hwrite);
      if (rd_pend_q) begin
        rdata_q <= rd_sel;
      end
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = ready_q;

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Bit 1 is fixed per state; writes to it are dropped by the masks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake1_q <= pwrsq_pkg::WAKE1_RST;
      wake2_q <= pwrsq_pkg::WAKE2_RST;
      awake_q <= pwrsq_pkg::AWAKE_RST;
    end else begin
      if (wr_w1) begin
        wake1_q <= (hwdata & pwrsq_pkg::WAKE_WMASK)
                 | (pwrsq_pkg::WAKE1_RST & ~pwrsq_pkg::WAKE_WMASK);
      end
      if (wr_w2) begin
        wake2_q <= (hwdata & pwrsq_pkg::WAKE_WMASK)
                 | (pwrsq_pkg::WAKE2_RST & ~pwrsq_pkg::WAKE_WMASK);
      end
      if (wr_aw) begin
        awake_q <= (hwdata & pwrsq_pkg::AWAKE_WMASK)
                 | (pwrsq_pkg::AWAKE_RST & ~pwrsq_pkg::AWAKE_WMASK);
      end
    end
  end

  // Self-clearing control strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_req_q <= 1'b0;
      reapply_q   <= 1'b0;
    end else begin
      sleep_req_q <= wr_ctrl & hwdata[pwrsq_pkg::CTRL_SLEEP];
      reapply_q   <= wr_ctrl & hwdata[pwrsq_pkg::CTRL_REAPPLY];
    end
  end

  // ****************************************************************
  // Dwell counter
  // ****************************************************************
  logic [DWELL_CNT_W-1:0] dwell_q;
  logic [DWELL_CNT_W-1:0] dwell_d;

  wire  [pwrsq_pkg::DWELL_W-1:0] dwell_n =
      (state_q == pwrsq_pkg::ST_WAKE1) ? wake1_q[pwrsq_pkg::DWELL_LSB +: pwrsq_pkg::DWELL_W]
                                       : wake2_q[pwrsq_pkg::DWELL_LSB +: pwrsq_pkg::DWELL_W];
  wire  [DWELL_CNT_W-1:0] dwell_len = DWELL_CNT_W'(1) << dwell_n;
  wire         dwell_done = (dwell_q >= dwell_len);
  wire         dwell_max  = &dwell_q;

  // Ticks of the selected sequencer clock, restarted on each new state
  assign dwell_d = (state_d != state_q)        ? '0 :
                   (seq_tick & ~dwell_max)     ? dwell_q + DWELL_CNT_W'(1) :
                   dwell_q;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  pwrsq_pkg::pwrsq_cfg_s w1_cfg;
  pwrsq_pkg::pwrsq_cfg_s w2_cfg;
  pwrsq_pkg::pwrsq_cfg_s aw_cfg;
  pwrsq_pkg::pwrsq_cfg_s off_cfg;
  pwrsq_pkg::pwrsq_cfg_s cfg_d;
  pwrsq_pkg::pwrsq_cfg_s applied_q;

  assign w1_cfg  = pwrsq_pkg::to_cfg(wake1_q);
  assign w2_cfg  = pwrsq_pkg::to_cfg(wake2_q);
  assign aw_cfg  = pwrsq_pkg::to_cfg(awake_q);
  assign off_cfg = '{tile_stop: 1'b1, default: 1'b0};

  wire  w1_good = pwrsq_pkg::all_good(w1_cfg, supply_good);
  wire  w2_good = pwrsq_pkg::all_good(w2_cfg, supply_good);
  wire  aw_good = pwrsq_pkg::all_good(aw_cfg, supply_good);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pwrsq_pkg::ST_RESET: begin
        state_d = pwrsq_pkg::ST_ASLEEP;
      end
      pwrsq_pkg::ST_ASLEEP: begin
        if (wake_req) begin
          state_d = pwrsq_pkg::ST_WAKE1;
        end
      end
      pwrsq_pkg::ST_WAKE1: begin
        if (dwell_done && w1_good) begin
          state_d = pwrsq_pkg::ST_WAKE2;
        end
      end
      pwrsq_pkg::ST_WAKE2: begin
        if (dwell_done && w2_good) begin
          state_d = pwrsq_pkg::ST_AWAKE_WAIT;
        end
      end
      pwrsq_pkg::ST_AWAKE_WAIT: begin
        if (aw_good) begin
          state_d = pwrsq_pkg::ST_AWAKE;
        end
      end
      pwrsq_pkg::ST_AWAKE: begin
        if (sleep_req_q) begin
          state_d = pwrsq_pkg::ST_SLEEP1;
        end
      end
      pwrsq_pkg::ST_SLEEP1: begin
        state_d = pwrsq_pkg::ST_SLEEP2;
      end
      pwrsq_pkg::ST_SLEEP2: begin
        state_d = pwrsq_pkg::ST_ASLEEP;
      end
      default: begin
        state_d = pwrsq_pkg::ST_RESET;
      end
    endcase
  end

  // Awake keeps the settings taken at entry until a re-apply strobe
  wire  take_awake = (state_q == pwrsq_pkg::ST_AWAKE_WAIT) | reapply_q;

  assign cfg_d = (state_q == pwrsq_pkg::ST_WAKE1) ? w1_cfg :
                 (state_q == pwrsq_pkg::ST_WAKE2) ? w2_cfg :
                 ((state_q == pwrsq_pkg::ST_AWAKE_WAIT) ||
                  (state_q == pwrsq_pkg::ST_AWAKE)) ?
                   (take_awake ? aw_cfg : applied_q) :
                 off_cfg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= pwrsq_pkg::ST_RESET;
      dwell_q   <= '0;
      applied_q <= '{tile_stop: 1'b1, default: 1'b0};
      seq_state <= 3'h0;
    end else begin
      state_q   <= state_d;
      dwell_q   <= dwell_d;
      applied_q <= cfg_d;
      seq_state <= pwrsq_pkg::state_code(state_d);
    end
  end

  assign supply_ctrl = applied_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_wake1_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE1) |=> (supply_ctrl == $past(w1_cfg)))
    else $error("first wake phase not driving its register");

  a_wake2_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE2) |=> (supply_ctrl == $past(w2_cfg)))
    else $error("second wake phase not driving its register");

  a_awake_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_AWAKE_WAIT) |=> (supply_ctrl == $past(aw_cfg)))
    else $error("awake settings not applied on entry");

  a_reapply_awake: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_AWAKE) && reapply_q
      |=> (supply_ctrl == $past(aw_cfg)))
    else $error("re-apply did not load awake settings");

  a_dwell_min: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE1) && (state_d != state_q)
      |-> (dwell_q >= dwell_len) && w1_good)
    else $error("first wake phase left early");

  a_dwell_good: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE2) && !w2_good |=> (state_q == pwrsq_pkg::ST_WAKE2))
    else $error("second wake phase left without power good");

  a_dwell_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE1) && (dwell_n == '0) && (dwell_q != '0)
      && w1_good |=> (state_q != pwrsq_pkg::ST_WAKE1))
    else $error("dwell of one cycle not honoured");

  a_ana_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_w1 |=> (wake1_q[pwrsq_pkg::BIT_ANA_EN] == pwrsq_pkg::WAKE1_RST[pwrsq_pkg::BIT_ANA_EN]))
    else $error("read-only analogue enable bit changed");

  a_state_code: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_state == pwrsq_pkg::state_code(state_q))
    else $error("state code mismatch");

  a_awake_stay: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_AWAKE) && !sleep_req_q |=> (state_q == pwrsq_pkg::ST_AWAKE))
    else $error("awake left without sleep request");

  // ****************************************************************
  // Field, counter and bus checks
  // ****************************************************************
  a_tile_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE2)
      |=> (supply_ctrl.tile_stop == $past(wake2_q[pwrsq_pkg::BIT_TILE_STOP])))
    else $error("tile clock gate not taken from its bit");

  a_ana_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE1)
      |=> (supply_ctrl.analogue_regulator_pfm == $past(wake1_q[pwrsq_pkg::BIT_ANA_PFM])))
    else $error("analogue modulation not taken from its bit");

  a_core_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE2)
      |=> (supply_ctrl.core_regulator_pfm == $past(wake2_q[pwrsq_pkg::BIT_CORE_PFM])))
    else $error("core modulation not taken from its bit");

  a_io_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE1)
      |=> (supply_ctrl.io_supply_output_en == $past(wake1_q[pwrsq_pkg::BIT_IO_EN])))
    else $error("io supply enable not taken from its bit");

  a_pll_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE2)
      |=> (supply_ctrl.pll_linear_regulator_en == $past(wake2_q[pwrsq_pkg::BIT_PLL_EN])))
    else $error("pll regulator enable not taken from its bit");

  a_core_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE1)
      |=> (supply_ctrl.core_regulator_en == $past(wake1_q[pwrsq_pkg::BIT_CORE_EN])))
    else $error("core regulator enable not taken from its bit");

  a_ana_wake2: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_w2 |=> (wake2_q[pwrsq_pkg::BIT_ANA_EN] == pwrsq_pkg::WAKE2_RST[pwrsq_pkg::BIT_ANA_EN]))
    else $error("read-only analogue enable bit changed in second phase");

  a_dwell_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_d != state_q) |=> (dwell_q == '0))
    else $error("dwell count not restarted on a new state");

  a_tick_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !seq_tick && (state_d == state_q) |=> $stable(dwell_q))
    else $error("dwell counted without a sequencer tick");

  a_wake2_min: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_WAKE2) && (state_d != state_q)
      |-> (dwell_q >= (DWELL_CNT_W'(1) << wake2_q[pwrsq_pkg::DWELL_LSB +: pwrsq_pkg::DWELL_W])))
    else $error("second wake phase left before its dwell");

  a_status_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_q && (addr_q == pwrsq_pkg::ADDR_STATUS)
      |=> (hrdata == (32'($past(seq_state)) << pwrsq_pkg::STATUS_LSB)))
    else $error("status read does not carry the state code");

  a_awake_resv: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_q && (addr_q == pwrsq_pkg::ADDR_AWAKE)
      |=> ((hrdata & ~(pwrsq_pkg::AWAKE_WMASK | pwrsq_pkg::AWAKE_RST)) == 32'h0000_0000))
    else $error("reserved awake bits read non-zero");

  a_sleep_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q != pwrsq_pkg::ST_AWAKE) && sleep_req_q |=> (state_q != pwrsq_pkg::ST_SLEEP1))
    else $error("sleep request taken outside awake");

  a_awake_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == pwrsq_pkg::ST_AWAKE) && !reapply_q |=> $stable(supply_ctrl))
    else $error("awake settings changed without re-apply");

endmodule : pwrsq_seq
`default_nettype wire

// ### rtl/pwrsq_pkg.sv
// Constants, types and helpers for the wake and awake power sequencer
package pwrsq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WAKE1  = 8'h10;
  localparam logic [7:0] ADDR_WAKE2  = 8'h14;
  localparam logic [7:0] ADDR_AWAKE  = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_CORE_EN    = 0;
  localparam int BIT_ANA_EN     = 1;
  localparam int BIT_PLL_EN     = 4;
  localparam int BIT_IO_EN      = 5;
  localparam int BIT_CORE_PFM   = 8;
  localparam int BIT_ANA_PFM    = 9;
  localparam int BIT_TILE_STOP  = 14;
  localparam int DWELL_LSB      = 16;
  localparam int DWELL_W        = 5;
  localparam int CTRL_SLEEP     = 1;
  localparam int CTRL_REAPPLY   = 6;
  localparam int STATUS_LSB     = 16;

  // Writable bits; bit 1 and reserved bits are never stored
  localparam logic [31:0] WAKE_WMASK  = 32'h001f_4331;
  localparam logic [31:0] AWAKE_WMASK = 32'h0000_4331;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] WAKE1_RST = 32'h0010_0020;
  localparam logic [31:0] WAKE2_RST = 32'h0010_0033;
  localparam logic [31:0] AWAKE_RST = 32'h0000_0033;

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [7:0] {
    ST_RESET      = 8'h01,
    ST_ASLEEP     = 8'h02,
    ST_WAKE1      = 8'h04,
    ST_WAKE2      = 8'h08,
    ST_AWAKE_WAIT = 8'h10,
    ST_AWAKE      = 8'h20,
    ST_SLEEP1     = 8'h40,
    ST_SLEEP2     = 8'h80
  } pwrsq_state_e;

  typedef struct packed {
    logic tile_stop;
    logic analogue_regulator_pfm;
    logic core_regulator_pfm;
    logic io_supply_output_en;
    logic pll_linear_regulator_en;
    logic analogue_regulator_en;
    logic core_regulator_en;
  } pwrsq_cfg_s;

  typedef struct packed {
    logic core_regulator;
    logic analogue_regulator;
    logic io_supply_output;
    logic pll_linear_regulator;
  } pwrsq_good_s;

  // Supply settings carried by a state register
  function automatic pwrsq_cfg_s to_cfg(input logic [31:0] r);
    pwrsq_cfg_s c;
    c.tile_stop               = r[BIT_TILE_STOP];
    c.analogue_regulator_pfm  = r[BIT_ANA_PFM];
    c.core_regulator_pfm      = r[BIT_CORE_PFM];
    c.io_supply_output_en     = r[BIT_IO_EN];
    c.pll_linear_regulator_en = r[BIT_PLL_EN];
    c.analogue_regulator_en   = r[BIT_ANA_EN];
    c.core_regulator_en       = r[BIT_CORE_EN];
    return c;
  endfunction : to_cfg

  // Every enabled supply reports good
  function automatic logic all_good(input pwrsq_cfg_s c, input pwrsq_good_s g);
    return (~c.core_regulator_en | g.core_regulator)
         & (~c.analogue_regulator_en | g.analogue_regulator)
         & (~c.io_supply_output_en | g.io_supply_output)
         & (~c.pll_linear_regulator_en | g.pll_linear_regulator);
  endfunction : all_good

  // Status code of a one-hot state
  function automatic logic [2:0] state_code(input pwrsq_state_e s);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (s[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction : state_code

endpackage : pwrsq_pkg

// ### testbench/pwrsq_supply_model.sv
// Regulator model that reports power good some cycles after enable
`timescale 1ns/1ps
`default_nettype none
module pwrsq_supply_model (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // Controls from the sequencer and answer
  input  wire pwrsq_pkg::pwrsq_cfg_s  supply_ctrl,
  input  wire logic [7:0]             good_dly,
  output pwrsq_pkg::pwrsq_good_s      supply_good
);
  logic [7:0] age_q [4];
  logic [3:0] en;

  assign en = {supply_ctrl.core_regulator_en, supply_ctrl.analogue_regulator_en,
               supply_ctrl.io_supply_output_en, supply_ctrl.pll_linear_regulator_en};

  // Good drops at once when off, so a stale good never helps the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!hresetn || !en[i]) begin
        age_q[i] <= 8'h00;
      end else if (age_q[i] != 8'hff) begin
        age_q[i] <= age_q[i] + 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      supply_good[i] = en[i] && (age_q[i] >= good_dly);
    end
  end
endmodule : pwrsq_supply_model
`default_nettype wire

// ### testbench/pwrsq_seq_bench.sv
// Self-checking bench for the wake and awake power sequencer
`timescale 1ns/1ps
`default_nettype none
module pwrsq_seq_bench;
  typedef struct packed {
    logic [2:0]  st;
    logic        chk;
    logic [6:0]  cfg;
    logic [15:0] min;
  } pwrsq_note_s;
  logic                   hclk      = 1'b0;
  logic                   hresetn   = 1'b0;
  logic                   hsel      = 1'b0;
  logic [31:0]            haddr     = 32'h0;
  logic [1:0]             htrans    = 2'h0;
  logic                   hwrite    = 1'b0;
  logic [31:0]            hwdata    = 32'h0;
  logic                   wake_req  = 1'b0;
  logic                   seq_tick  = 1'b1;
  logic                   half_rate = 1'b0;
  logic [7:0]             good_dly  = 8'h02;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [2:0]             seq_state;
  pwrsq_pkg::pwrsq_good_s supply_good;
  pwrsq_pkg::pwrsq_cfg_s  supply_ctrl;
  logic [31:0]            reg_m [3];
  logic [31:0]            msk [3]   = '{32'h001f_4331, 32'h001f_4331, 32'h0000_4331};
  logic [31:0]            rst [3]   = '{32'h0010_0020, 32'h0010_0033, 32'h0000_0033};
  logic [31:0]            rnd       = 32'h9484b75a;
  logic [31:0]            rdq [$];
  pwrsq_note_s            nq [$];
  pwrsq_note_s            cur       = '0;
  logic [2:0]             last_st   = 3'h0;
  logic                   pend      = 1'b0;
  logic                   rd_ph     = 1'b0;
  int                     dwell     = 0;
  int                     error_cnt = 0;
  int                     n_tests   = 0;

  always #5 hclk = ~hclk;
  always @(posedge hclk) seq_tick <= half_rate ? ~seq_tick : 1'b1;

  pwrsq_seq #(.DWELL_CNT_W(32)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_req(wake_req), .seq_tick(seq_tick),
    .supply_good(supply_good), .supply_ctrl(supply_ctrl), .seq_state(seq_state));
  pwrsq_supply_model i_supply (
    .hclk(hclk), .hresetn(hresetn), .supply_ctrl(supply_ctrl), .good_dly(good_dly),
    .supply_good(supply_good));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [6:0] ecfg(input logic [31:0] r);
    return {r[14], r[9], r[8], r[5], r[4], r[1], r[0]};
  endfunction : ecfg

  function automatic logic [15:0] dmin(input int n, input logic h);
    return h ? (16'd2 << n) - 16'd1 : 16'd1 << n;
  endfunction : dmin

  function automatic pwrsq_note_s note(input logic [2:0] s, input logic c,
                                       input logic [6:0] g, input logic [15:0] m);
    return {s, c, g, m};
  endfunction : note

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Holds each phase until hready is sampled high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin error_cnt++; close_out(); end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin error_cnt++; close_out(); end
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    i = (a - 8'h10) >> 2;
    ahb(1'b1, a, d);
    if (a >= 8'h10 && a <= 8'h18) reg_m[i] = (d & msk[i]) | (rst[i] & 32'h2);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_st(input logic [2:0] s);
    int k;
    k = 0;
    while (seq_state !== s && k < 3000) begin @(posedge hclk); k++; end
    if (k >= 3000) begin error_cnt++; close_out(); end
  endtask : wait_st

  // ****************************************************************
  // Watchers
  // ****************************************************************
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && rdq.size() > 0) begin
      rd_ph = 1'b0;
      check("hrdata", hrdata, rdq.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) rd_ph = 1'b1;
  end

  always @(negedge hclk) begin
    if (pend) begin
      pend = 1'b0;
      check("supply_ctrl", {25'h0, supply_ctrl}, {25'h0, cur.cfg});
    end
    if (hresetn && seq_state !== last_st) begin
      check("dwell", {31'h0, dwell >= cur.min}, 32'h1);
      if (nq.size() == 0) begin error_cnt++; close_out(); end
      cur = nq.pop_front();
      check("seq_state", {29'h0, seq_state}, {29'h0, cur.st});
      pend = cur.chk;
      last_st = seq_state;
      dwell = 0;
    end
    dwell++;
  end

  initial begin
    logic [31:0] d;
    logic [6:0]  old;
    logic [15:0] m1;
    for (int i = 0; i < 3; i++) reg_m[i] = rst[i];
    repeat (20) @(posedge hclk);
    nq.push_back(note(3'h1, 1'b1, 7'h40, 16'h0));
    hresetn <= 1'b1;
    for (int i = 0; i < 3; i++) rd(8'h10 + 8'(4 * i), rst[i]);
    rd(8'h24, 32'h0001_0000);
    rd(8'h3c, 32'h0);
    wr(8'h00, 32'h42);
    repeat (3) @(posedge hclk);
    check("refused", {25'h0, supply_ctrl}, 32'h40);
    for (int run = 0; run < 3; run++) begin
      half_rate <= (run == 2);
      good_dly <= (run == 1) ? 8'd40 : 8'd2;
      for (int i = 0; i < 3; i++) begin
        rnd = xs(rnd);
        d = rnd;
        if (i == 0) d = {rnd[31:21], 5'(run), rnd[15:1], 1'b1};
        if (i == 1) d = {rnd[31:21], 5'(2 - run), rnd[15:0]};
        wr(8'h10 + 8'(4 * i), d);
        rd(8'h10 + 8'(4 * i), reg_m[i]);
      end
      m1 = (run == 1) ? 16'd40 : dmin(run, run == 2);
      nq.push_back(note(3'h2, 1'b1, ecfg(reg_m[0]), m1));
      nq.push_back(note(3'h3, 1'b1, ecfg(reg_m[1]), dmin(2 - run, run == 2)));
      nq.push_back(note(3'h4, 1'b0, 7'h0, 16'h0));
      nq.push_back(note(3'h5, 1'b1, ecfg(reg_m[2]), 16'h0));
      wake_req <= 1'b1;
      wait_st(3'h5);
      wake_req <= 1'b0;
      rd(8'h24, 32'h0005_0000);
      old = ecfg(reg_m[2]);
      rnd = xs(rnd);
      wr(8'h18, rnd);
      repeat (3) @(posedge hclk);
      check("held", {25'h0, supply_ctrl}, {25'h0, old});
      wr(8'h00, 32'h40);
      repeat (3) @(posedge hclk);
      check("reapply", {25'h0, supply_ctrl}, {25'h0, ecfg(reg_m[2])});
      nq.push_back(note(3'h6, 1'b0, 7'h0, 16'h0));
      nq.push_back(note(3'h7, 1'b0, 7'h0, 16'h0));
      nq.push_back(note(3'h1, 1'b1, 7'h40, 16'h0));
      wr(8'h00, 32'h2);
      wait_st(3'h1);
    end
    repeat (4) @(posedge hclk);
    close_out();
  end
endmodule : pwrsq_seq_bench
`default_nettype wire
